/* File: rtl/dac_cal_map.vh */
`ifndef DAC_CAL_MAP_VH
`define DAC_CAL_MAP_VH
// Notes on behaviour
// [RULE1] channels 0-3 with offset code A form group A, 4-7 with B form group B
// [RULE2] each channel latch holds a 16-bit code that alone sets its output
// [RULE3] output gain six or four chosen by the configuration gain bit
// [RULE4] corrected code = input*(gain+2^15)/2^16 + signed zero, into data register
// [RULE5] write of input, gain or zero with engine on recomputes that channel
// [RULE6] gain coefficient spans 0.5 to 1.5, zero spans -32768 to +32767 LSB
// [RULE7] one correction engine serves all eight channels in turn
// [RULE8] engine enable bit: off passes written input straight to data register
// [RULE9] engine off: gain/zero writes only store, read back unchanged
// [RULE10] single-supply operation holds both group offset converters powered down
// [RULE11] dual-supply offset defaults 39322 (gain six), 43691 (gain four), per group
// [RULE12] reset: gain 32768, zero 0, input 0000h
// [RULE13] format pin: low straight binary, high twos complement, input and offset
// [RULE14] bipolar: binary 8000h zero; twos complement 0000h zero
// [RULE15] unipolar: twos complement 8000h zero output; binary 0000h zero
// [RULE16] gain always straight binary, zero always twos complement
// [RULE17] reads return data in the format they were written
// [RULE18] gain bit change reloads offset codes with new gain defaults
// [RULE19] correction requests queue per channel and are served in order; code keeps one pending bit per channel, served round-robin
// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
`define REG_OFS_A 8'h08
`define REG_OFS_B 8'h0c
`define REG_INPUT_BASE 8'h20
`define REG_GAIN_BASE 8'h40
`define REG_ZERO_BASE 8'h60
`define REG_DATA_BASE 8'h80
`define CFG_ENG_BIT 0
`define CFG_GAIN4_BIT 1
`define CFG_SINGLE_BIT 2
// ----------------------------------------
// reset values
// ----------------------------------------
`define GAIN_RST 16'h8000
`define ZERO_RST 16'h0000
`define INPUT_RST 16'h0000
`define OFS_DEF_G6 16'h999a
`define OFS_DEF_G4 16'haaab
`define CFG_RST 3'h0
`endif

/* File: rtl/dac_calibration_datapath.v */
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "dac_cal_map.vh"
module dac_calibration_datapath (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   input wire data_format_select_pin,
   input wire [2:0] latch_ch_i,
   input wire latch_load_i,
   output reg [15:0] latch_code_o,
   output reg [2:0] latch_ch_o,
   output reg latch_valid_o,
   output reg [15:0] group_offset_code_a_o,
   output reg [15:0] group_offset_code_b_o,
   output reg offset_pd_o,
   output reg gain_sel_o
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   reg [15:0] input_r [0:7];
   reg [15:0] gain_r [0:7];
   reg [15:0] zero_r [0:7];
   reg [15:0] data_r [0:7];
   reg [15:0] ofs_a_r;
   reg [15:0] ofs_b_r;
   reg [2:0] cfg_r;
   reg [7:0] pend_r;
   reg [0:0] state_r;
   reg [0:0] state_nxt;
   reg [2:0] eng_ch_r;
   reg [2:0] eng_ch_nxt;
   reg [2:0] rr_r;
   reg [2:0] rr_nxt;
   // ----------------------------------------
   // engine states
   // ----------------------------------------
   // a channel slot is two cycles: pick, then store
   localparam [0:0] ENG_IDLE = 1'b0;
   localparam [0:0] ENG_CALC = 1'b1;
   wire busy = state_r == ENG_CALC;
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire req = cyc_i & stb_i & ~ack_o;
   wire wr = req & we_i & sel_i[0] & sel_i[1];
   wire [2:0] ch = adr_i[4:2];
   wire [2:0] region = adr_i[7:5];
   wire hit_in = region == 3'h1;
   wire hit_gn = region == 3'h2;
   wire hit_zr = region == 3'h3;
   wire hit_dt = region == 3'h4;
   wire hit_cfg = adr_i == `REG_CONFIG;
   wire hit_sts = adr_i == `REG_STATUS;
   wire hit_ofa = adr_i == `REG_OFS_A;
   wire hit_ofb = adr_i == `REG_OFS_B;
   // ----------------------------------------
   // configuration fields
   // ----------------------------------------
   wire eng_on = cfg_r[`CFG_ENG_BIT];
   wire gain4 = cfg_r[`CFG_GAIN4_BIT];
   wire single = cfg_r[`CFG_SINGLE_BIT];
   wire fmt = data_format_select_pin;
   wire [15:0] fmt_flip = {fmt, 15'h0000};
   // ----------------------------------------
   // correction engine operands
   // ----------------------------------------
   wire [15:0] op_in = input_r[eng_ch_r];
   wire [15:0] op_gain = gain_r[eng_ch_r];
   wire [15:0] op_zero = zero_r[eng_ch_r];
   // ----------------------------------------
   // correction arithmetic
   // ----------------------------------------
   // input offset to straight binary before the multiply so both formats scale alike
   wire [15:0] in_ub = op_in ^ fmt_flip; // RULE13
   wire [16:0] gfac = {1'b0, op_gain} + 17'h08000; // RULE4 RULE6 RULE16
   wire [32:0] prod = {17'h00000, in_ub} * {16'h0000, gfac};
   // bit 32 of the product is live for gains above one
   wire [16:0] scaled = prod[32:16]; // RULE4
   wire signed [17:0] zero_ext = $signed({{2{op_zero[15]}}, op_zero}); // RULE16
   wire signed [17:0] sum = $signed({1'b0, scaled}) + zero_ext; // RULE4
   // saturate rather than wrap so an overrange zero cannot flip the output
   wire under = sum[17];
   wire over = ~sum[17] & sum[16];
   wire [15:0] sat = under ? 16'h0000 : (over ? 16'hffff : sum[15:0]);
   wire [15:0] eng_res = sat ^ fmt_flip; // RULE13 RULE17
   // ----------------------------------------
   // round-robin pick
   // ----------------------------------------
   // next pending channel after the last served one
   reg [2:0] pick;
   reg found;
   integer k;
   always @* begin
      pick = 3'h0;
      found = 1'b0;
      for (k = 7; k >= 0; k = k - 1) begin
         if (pend_r[(rr_r + k[2:0] + 3'h1) & 3'h7]) begin
            pick = (rr_r + k[2:0] + 3'h1) & 3'h7;
            found = 1'b1;
         end
      end
   end
   // ----------------------------------------
   // engine sequencing, one channel per two cycles
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      eng_ch_nxt = eng_ch_r;
      rr_nxt = rr_r;
      case (state_r)
         ENG_IDLE: begin
            if (found & eng_on) begin
               state_nxt = ENG_CALC; // RULE7 RULE19
               eng_ch_nxt = pick;
               rr_nxt = pick;
            end
         end
         ENG_CALC: begin
            state_nxt = ENG_IDLE; // RULE7
         end
         default: begin
            state_nxt = ENG_IDLE;
         end
      endcase
   end
   wire start = (state_r == ENG_IDLE) & found & eng_on;
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ENG_IDLE;
         eng_ch_r <= 3'h0;
         rr_r <= 3'h7;
      end else begin
         state_r <= state_nxt;
         eng_ch_r <= eng_ch_nxt;
         rr_r <= rr_nxt;
      end
   end
   // ----------------------------------------
   // per-channel registers
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : chan
         wire sel_ch = wr & (ch == g);
         wire wr_in = sel_ch & hit_in;
         wire wr_gn = sel_ch & hit_gn;
         wire wr_zr = sel_ch & hit_zr;
         wire wr_dt = sel_ch & hit_dt;
         wire done = busy & (eng_ch_r == g);
         wire taken = start & (pick == g);
         wire recalc = eng_on & (wr_in | wr_gn | wr_zr);
         always @(posedge clk_i) begin
            if (rst_i) begin
               input_r[g] <= `INPUT_RST; // RULE12
               gain_r[g] <= `GAIN_RST; // RULE12
               zero_r[g] <= `ZERO_RST; // RULE12
               data_r[g] <= 16'h0000;
               pend_r[g] <= 1'b0;
            end else begin
               if (wr_in) begin
                  input_r[g] <= dat_i[15:0]; // RULE17
               end
               if (wr_gn) begin
                  gain_r[g] <= dat_i[15:0]; // RULE9
               end
               if (wr_zr) begin
                  zero_r[g] <= dat_i[15:0]; // RULE9
               end
               if (wr_in & ~eng_on) begin
                  data_r[g] <= dat_i[15:0]; // RULE8
               end else if (wr_dt & ~eng_on) begin
                  data_r[g] <= dat_i[15:0]; // RULE8
               end else if (done) begin
                  data_r[g] <= eng_res; // RULE4 RULE5
               end
               // a new write while queued or in flight sets again; set wins over clear
               if (recalc) begin
                  pend_r[g] <= 1'b1; // RULE5 RULE19
               end else if (~eng_on) begin
                  pend_r[g] <= 1'b0; // RULE9
               end else if (taken) begin
                  pend_r[g] <= 1'b0; // RULE19
               end
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // configuration register
   // ----------------------------------------
   wire wr_cfg = wr & hit_cfg;
   wire new_g4 = dat_i[`CFG_GAIN4_BIT];
   wire gain_flip = wr_cfg & (new_g4 != gain4);
   always @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r <= `CFG_RST;
      end else if (wr_cfg) begin
         cfg_r <= dat_i[2:0]; // RULE3 RULE8
      end
   end
   // ----------------------------------------
   // offset codes
   // ----------------------------------------
   wire [15:0] ofs_def = new_g4 ? `OFS_DEF_G4 : `OFS_DEF_G6; // RULE11
   // stored as the pin format reads it, so read back matches what a host writes
   wire [15:0] ofs_reload = ofs_def ^ fmt_flip; // RULE13
   wire [15:0] ofs_boot = `OFS_DEF_G6 ^ fmt_flip; // RULE11 RULE13
   always @(posedge clk_i) begin
      if (rst_i) begin
         ofs_a_r <= ofs_boot; // RULE11
         ofs_b_r <= ofs_boot; // RULE1
      end else if (gain_flip) begin
         ofs_a_r <= ofs_reload; // RULE18
         ofs_b_r <= ofs_reload; // RULE18 RULE1
      end else begin
         if (wr & hit_ofa) begin
            ofs_a_r <= dat_i[15:0];
         end
         if (wr & hit_ofb) begin
            ofs_b_r <= dat_i[15:0];
         end
      end
   end
   // ----------------------------------------
   // read mux
   // ----------------------------------------
   reg [31:0] rd;
   always @* begin
      rd = 32'h00000000;
      case (region)
         3'h0: begin
            if (hit_cfg) begin
               rd = {29'h0, cfg_r};
            end else if (hit_sts) begin
               rd = {23'h0, busy, pend_r};
            end else if (hit_ofa) begin
               rd = {16'h0000, ofs_a_r}; // RULE17
            end else if (hit_ofb) begin
               rd = {16'h0000, ofs_b_r}; // RULE17
            end
         end
         3'h1: begin
            rd = {16'h0000, input_r[ch]}; // RULE17
         end
         3'h2: begin
            rd = {16'h0000, gain_r[ch]}; // RULE9 RULE16
         end
         3'h3: begin
            rd = {16'h0000, zero_r[ch]}; // RULE9 RULE16
         end
         3'h4: begin
            rd = {16'h0000, data_r[ch]};
         end
         default: begin
            rd = 32'h00000000;
         end
      endcase
   end
   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         // ack blocks its own request, so every access is exactly one pulse
         ack_o <= req;
         if (req) begin
            dat_o <= rd;
         end else begin
            dat_o <= 32'h00000000;
         end
      end
   end
   // ----------------------------------------
   // converter latch
   // ----------------------------------------
   // latch is loaded by the external load strobe only; the code alone sets the level
   always @(posedge clk_i) begin
      if (rst_i) begin
         latch_code_o <= 16'h0000;
         latch_ch_o <= 3'h0;
         latch_valid_o <= 1'b0;
      end else begin
         latch_valid_o <= latch_load_i;
         latch_ch_o <= latch_ch_i; // RULE1
         if (latch_load_i) begin
            latch_code_o <= data_r[latch_ch_i]; // RULE2 RULE14 RULE15
         end
      end
   end
   // ----------------------------------------
   // offset converter outputs
   // ----------------------------------------
   wire [15:0] ofs_a_out = single ? 16'h0000 : ofs_a_r; // RULE10
   wire [15:0] ofs_b_out = single ? 16'h0000 : ofs_b_r; // RULE10
   always @(posedge clk_i) begin
      if (rst_i) begin
         group_offset_code_a_o <= 16'h0000;
         group_offset_code_b_o <= 16'h0000;
         offset_pd_o <= 1'b0;
         gain_sel_o <= 1'b0;
      end else begin
         offset_pd_o <= single; // RULE10
         group_offset_code_a_o <= ofs_a_out;
         group_offset_code_b_o <= ofs_b_out;
         gain_sel_o <= gain4; // RULE3
      end
   end
endmodule

/* File: tb/dac_cal_props.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checks
// ----------------------------------------
module dac_cal_props (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire data_format_select_pin,
   input wire [2:0] latch_ch_i,
   input wire latch_load_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire [2:0] latch_ch_o,
   input wire latch_valid_o,
   input wire [15:0] group_offset_code_a_o,
   input wire [15:0] group_offset_code_b_o,
   input wire offset_pd_o,
   input wire gain_sel_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   property p_ack_req; ack_o |-> $past(cyc_i && stb_i); endproperty
   property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
   property p_pd_zero; offset_pd_o |-> (group_offset_code_a_o | group_offset_code_b_o) == 16'h0;
   endproperty
   // reload lands in the same cycle as the gain bit; the check allows up to two
   property p_reload;
      $changed(gain_sel_o) && !offset_pd_o |-> ##[0:2] group_offset_code_a_o ==
         ((gain_sel_o ? 16'haaab : 16'h999a) ^ {data_format_select_pin, 15'h0})
         && group_offset_code_b_o == group_offset_code_a_o;
   endproperty
   property p_latch_valid; latch_load_i |-> ##[1:2] latch_valid_o; endproperty
   property p_latch_ch; $rose(latch_valid_o) |-> latch_ch_o == $past(latch_ch_i, 1)
      || latch_ch_o == $past(latch_ch_i, 2); endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_req: assert property (p_ack_req) else $error("ack without request");
   a_dat_idle: assert property (p_dat_idle) else $error("read data not zero when idle");
   a_pd_zero: assert property (p_pd_zero) else $error("offset code while powered down");
   a_reload: assert property (p_reload) else $error("offset not reloaded");
   a_latch_valid: assert property (p_latch_valid) else $error("latch load not seen");
   a_latch_ch: assert property (p_latch_ch) else $error("latch channel wrong");
   c_latch: cover property (latch_valid_o);
   c_gain: cover property ($changed(gain_sel_o));
   c_pd: cover property (offset_pd_o);
endmodule

/* File: tb/host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// host bus master
// ----------------------------------------
module host_model (
   input wire clk_i,
   input wire ack_i,
   input wire [31:0] dat_i,
   output reg cyc_o = 1'b0,
   output reg stb_o = 1'b0,
   output reg we_o = 1'b0,
   output reg [7:0] adr_o = 8'h0,
   output reg [3:0] sel_o = 4'h0,
   output reg [31:0] dat_o = 32'h0
);
   // released address and data lines flip so stale values never look valid
   task xfer(input w, input [7:0] a, input [15:0] d, output [15:0] q);
      begin
         @(posedge clk_i);
         {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, 16'h0, d};
         do @(posedge clk_i); while (ack_i !== 1'b1);
         q = dat_i[15:0];
         {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'b000, ~a, ~dat_o};
      end
   endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg fmt = 1'b0;
   reg [2:0] lch_i = 3'h0;
   reg lload = 1'b0;
   wire cyc, stb, we, ack, lvalid, pd, gsel;
   wire [7:0] adr;
   wire [3:0] sel;
   wire [31:0] wdat, rdat;
   wire [15:0] code, ofs_a, ofs_b;
   wire [2:0] lch_o;
   integer n_fail = 0;
   integer total_checks = 0;
   reg [15:0] q;
   reg [3:0] i;
   host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   dac_calibration_datapath dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .data_format_select_pin(fmt), .latch_ch_i(lch_i), .latch_load_i(lload),
      .latch_code_o(code), .latch_ch_o(lch_o), .latch_valid_o(lvalid),
      .group_offset_code_a_o(ofs_a), .group_offset_code_b_o(ofs_b), .offset_pd_o(pd),
      .gain_sel_o(gsel));
   initial forever #10 clk_i = ~clk_i;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input [15:0] seen, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task rchk(input [7:0] a, input [15:0] exp);
      begin
         host.xfer(1'b0, a, 16'h0, q);
         check(q, exp);
      end
   endtask
   task report_and_stop;
      begin
         if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      begin
         rchk(8'h40, 16'h8000);
         rchk(8'h60, 16'h0000);
         rchk(8'h20, 16'h0000);
         rchk(8'h08, 16'h999a);
         rchk(8'h10, 16'h0000);
      end
   endtask
   task t_off;
      begin
         wr(8'h24, 16'h1234);
         rchk(8'h84, 16'h1234);
         wr(8'h44, 16'h1111);
         rchk(8'h44, 16'h1111);
         rchk(8'h84, 16'h1234);
         wr(8'h44, 16'h8000);
         @(posedge clk_i);
         {lch_i, lload} <= 4'h3;
         @(posedge clk_i);
         lload <= 1'b0;
         repeat (3) @(posedge clk_i);
         check(code, 16'h1234);
      end
   endtask
   task t_engine;
      begin
         for (i = 0; i < 8; i = i + 1)
            wr(8'h60 + {i[2:0], 2'b00}, {12'h0, i} - 16'h4);
         wr(8'h00, 16'h1);
         // each input transfer outlasts the two-cycle engine slot, so no input waits behind another
         for (i = 0; i < 8; i = i + 1)
            wr(8'h20 + {i[2:0], 2'b00}, {i, 12'h0} + 16'h1000);
         repeat (30) @(posedge clk_i);
         for (i = 0; i < 8; i = i + 1)
            rchk(8'h80 + {i[2:0], 2'b00}, {i, 12'h0} + 16'h0ffc + {12'h0, i});
         rchk(8'h04, 16'h0000);
         wr(8'h40, 16'h0000);
         repeat (10) @(posedge clk_i);
         rchk(8'h80, 16'h07fc);
         rchk(8'h60, 16'hfffc);
      end
   endtask
   task t_cfg;
      begin
         wr(8'h00, 16'h3);
         repeat (3) @(posedge clk_i);
         check(gsel, 16'h1);
         check(ofs_a, 16'haaab);
         check(ofs_b, 16'haaab);
         rchk(8'h0c, 16'haaab);
         wr(8'h00, 16'h4);
         repeat (3) @(posedge clk_i);
         check(pd, 16'h1);
         check(ofs_a, 16'h0);
      end
   endtask
   task t_twos;
      begin
         @(posedge clk_i);
         fmt <= 1'b1;
         wr(8'h00, 16'h3);
         repeat (3) @(posedge clk_i);
         check(ofs_a, 16'h2aab);
         rchk(8'h08, 16'h2aab);
         // large gain overflows into the top product bit, then saturates
         wr(8'h48, 16'hffff);
         wr(8'h60, 16'h8000);
         repeat (10) @(posedge clk_i);
         rchk(8'h88, 16'h7fff);
         rchk(8'h80, 16'h8000);
         rchk(8'h48, 16'hffff);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_off;
      t_engine;
      t_cfg;
      t_twos;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail = n_fail + 1;
      report_and_stop;
   end
endmodule
bind dac_calibration_datapath dac_cal_props props (.clk_i, .rst_i, .cyc_i, .stb_i,
   .data_format_select_pin, .latch_ch_i, .latch_load_i, .dat_o, .ack_o, .latch_ch_o,
   .latch_valid_o, .group_offset_code_a_o, .group_offset_code_b_o, .offset_pd_o, .gain_sel_o);
